// >>> core/pssc_pkg.sv
// shared constants for the pipelined sync sram control front end
package pssc_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int BURST_W = 2;
	// ------------------------------------------------------------
	// reset values and the burst step
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] RST_ADDR = 18'h0_0000;
	localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
	localparam logic [LANES-1:0] RST_LANES = 4'h0;
	localparam logic [LANES-1:0] ALL_LANES = 4'hf;
	localparam logic [DATA_W-1:0] RST_DATA = 36'h0_0000_0000;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
endpackage

// >>> core/pssc_sram_front.sv
// synchronous control front end of a pipelined burst sram
`timescale 1ns/1ps
module pssc_sram_front #(
	parameter bit HAS_THIRD_SELECT = 1'b1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [pssc_pkg::ADDR_W-1:0] addrIn,
	input wire logic processorAddrStrobe_n,
	input wire logic controllerAddrStrobe_n,
	input wire logic burstAdvance_n,
	input wire logic globalWrite_n,
	input wire logic laneWriteEnable_n,
	input wire logic [pssc_pkg::LANES-1:0] byteLaneSelect_n,
	input wire logic primarySelect_n,
	input wire logic secondSelect,
	input wire logic thirdSelect_n,
	input wire logic outputEnable_n,
	input wire logic sleepRequest,
	input wire logic [pssc_pkg::DATA_W-1:0] dataIn,
	output logic [pssc_pkg::DATA_W-1:0] dataOut,
	output logic dataOe_n,
	input wire logic [pssc_pkg::DATA_W-1:0] arrayRdData,
	output logic [pssc_pkg::ADDR_W-1:0] arrayAddr,
	output logic [pssc_pkg::LANES-1:0] arrayLaneWr,
	output logic [pssc_pkg::DATA_W-1:0] arrayWrData,
	output logic sleeping
);
	import pssc_pkg::*;

	if (ADDR_W <= BURST_W || LANES < 1 || DATA_W != LANES * LANE_W) begin : gChk
		$error("pssc_sram_front: geometry not supported");
	end

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] addrSmp_ff;
	logic procStbSmp_n_ff;
	logic ctrlStbSmp_n_ff;
	logic stepSmp_n_ff;
	logic allWrSmp_n_ff;
	logic laneEnSmp_n_ff;
	logic [LANES-1:0] bwSmp_n_ff;
	logic sel1Smp_n_ff;
	logic sel2Smp_ff;
	logic sel3Smp_n_ff;
	logic [DATA_W-1:0] dataSmp_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addrSmp_ff <= RST_ADDR;
			procStbSmp_n_ff <= 1'b1;
			ctrlStbSmp_n_ff <= 1'b1;
			stepSmp_n_ff <= 1'b1;
			allWrSmp_n_ff <= 1'b1;
			laneEnSmp_n_ff <= 1'b1;
			bwSmp_n_ff <= ALL_LANES;
			sel1Smp_n_ff <= 1'b1;
			sel2Smp_ff <= 1'b0;
			sel3Smp_n_ff <= 1'b1;
			dataSmp_ff <= RST_DATA;
		end else begin
			addrSmp_ff <= addrIn;
			procStbSmp_n_ff <= processorAddrStrobe_n;
			ctrlStbSmp_n_ff <= controllerAddrStrobe_n;
			stepSmp_n_ff <= burstAdvance_n;
			allWrSmp_n_ff <= globalWrite_n;
			laneEnSmp_n_ff <= laneWriteEnable_n;
			bwSmp_n_ff <= byteLaneSelect_n;
			sel1Smp_n_ff <= primarySelect_n;
			sel2Smp_ff <= secondSelect;
			sel3Smp_n_ff <= thirdSelect_n;
			dataSmp_ff <= dataIn;
		end
	end

	// ------------------------------------------------------------
	// asynchronous pins: two-stage synchronisers
	// ------------------------------------------------------------
	// output enable and sleep come from outside any clock, so they pay
	// two cycles of latency rather than risk a metastable direction flip
	logic oeMeta_n_ff;
	logic oeSync_n_ff;
	logic sleepMeta_ff;
	logic sleepSync_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			oeMeta_n_ff <= 1'b1;
			oeSync_n_ff <= 1'b1;
			sleepMeta_ff <= 1'b0;
			sleepSync_ff <= 1'b0;
		end else begin
			oeMeta_n_ff <= outputEnable_n;
			oeSync_n_ff <= oeMeta_n_ff;
			sleepMeta_ff <= sleepRequest;
			sleepSync_ff <= sleepMeta_ff;
		end
	end

	// ------------------------------------------------------------
	// selection and strobe decode
	// ------------------------------------------------------------
	logic [ADDR_W-BURST_W-1:0] addrHi_ff;
	logic [BURST_W-1:0] burstCnt_ff;
	logic burstActive_ff;
	logic deselected_ff;

	wire thirdOk = ~sel3Smp_n_ff | ~HAS_THIRD_SELECT;
	wire selActive = ~sel1Smp_n_ff & sel2Smp_ff & thirdOk;
	wire procStrobe = ~procStbSmp_n_ff & ~sel1Smp_n_ff;
	wire ctrlStrobe = ~ctrlStbSmp_n_ff & ~procStrobe;
	wire anyStrobe = (procStrobe | ctrlStrobe) & ~sleepSync_ff;
	wire startCycle = anyStrobe & selActive;
	wire deselCycle = anyStrobe & ~selActive;
	wire advStep = ~anyStrobe & ~stepSmp_n_ff & burstActive_ff & ~sleepSync_ff;
	wire accessCycle = startCycle | (burstActive_ff & ~anyStrobe & ~sleepSync_ff);

	// ------------------------------------------------------------
	// write qualification
	// ------------------------------------------------------------
	wire laneQual = ~laneEnSmp_n_ff;
	wire [LANES-1:0] laneSel = laneQual ? ~bwSmp_n_ff : RST_LANES;
	wire [LANES-1:0] wrLanes = ~allWrSmp_n_ff ? ALL_LANES : laneSel;
	wire [LANES-1:0] cycLanes = accessCycle ? wrLanes : RST_LANES;
	wire wrCycle = |cycLanes;
	wire rdCycle = accessCycle & ~wrCycle;
	wire firstRead = rdCycle & deselected_ff;

	// ------------------------------------------------------------
	// address and burst counter
	// ------------------------------------------------------------
	// the counter only ever carries its own two bits, so a burst
	// wraps inside the aligned group of four and never touches the high part
	wire [BURST_W-1:0] nxt_burstCnt = startCycle ? addrSmp_ff[BURST_W-1:0] :
		(advStep ? burstCnt_ff + BURST_STEP : burstCnt_ff);
	wire [ADDR_W-BURST_W-1:0] nxt_addrHi = startCycle ? addrSmp_ff[ADDR_W-1:BURST_W] : addrHi_ff;
	wire nxt_burstActive = startCycle | (burstActive_ff & ~deselCycle);
	wire nxt_deselected = deselCycle | (deselected_ff & ~startCycle);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addrHi_ff <= RST_ADDR[ADDR_W-1:BURST_W];
			burstCnt_ff <= RST_BURST;
			burstActive_ff <= 1'b0;
			deselected_ff <= 1'b1;
		end else begin
			addrHi_ff <= nxt_addrHi;
			burstCnt_ff <= nxt_burstCnt;
			burstActive_ff <= nxt_burstActive;
			deselected_ff <= nxt_deselected;
		end
	end

	// ------------------------------------------------------------
	// array side and data pins
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] arrayAddr_ff;
	logic [LANES-1:0] arrayLaneWr_ff;
	logic [DATA_W-1:0] arrayWrData_ff;
	logic [DATA_W-1:0] dataOut_ff;
	logic dataOe_n_ff;
	logic readPend_ff;
	logic maskFirst_ff;
	logic sleeping_ff;

	// the array answers combinationally for arrayAddr, so one register
	// here gives the single pipeline stage seen at the pins
	wire driveNow = ~oeSync_n_ff & ~maskFirst_ff & ~sleepSync_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			arrayAddr_ff <= RST_ADDR;
			arrayLaneWr_ff <= RST_LANES;
			arrayWrData_ff <= RST_DATA;
			dataOut_ff <= RST_DATA;
			dataOe_n_ff <= 1'b1;
			readPend_ff <= 1'b0;
			maskFirst_ff <= 1'b0;
			sleeping_ff <= 1'b0;
		end else begin
			arrayAddr_ff <= {nxt_addrHi, nxt_burstCnt};
			arrayLaneWr_ff <= cycLanes;
			arrayWrData_ff <= dataSmp_ff;
			readPend_ff <= rdCycle;
			maskFirst_ff <= firstRead;
			dataOut_ff <= readPend_ff ? arrayRdData : dataOut_ff;
			dataOe_n_ff <= ~driveNow;
			sleeping_ff <= sleepSync_ff;
		end
	end

	assign arrayAddr = arrayAddr_ff;
	assign arrayLaneWr = arrayLaneWr_ff;
	assign arrayWrData = arrayWrData_ff;
	assign dataOut = dataOut_ff;
	assign dataOe_n = dataOe_n_ff;
	assign sleeping = sleeping_ff;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence sStart;
		startCycle;
	endsequence
	sequence sReadIssue;
		rdCycle ##1 readPend_ff;
	endsequence

	input_sample_a: assert property (
		##1 (addrSmp_ff == $past(addrIn)) && (allWrSmp_n_ff == $past(globalWrite_n)))
		else $error("synchronous input not sampled on the edge");
	addr_capture_a: assert property (
		sStart |=> arrayAddr_ff[ADDR_W-1:BURST_W] == $past(addrSmp_ff[ADDR_W-1:BURST_W]))
		else $error("address not captured on a strobe");
	burst_load_a: assert property (
		sStart |=> burstCnt_ff == $past(addrSmp_ff[BURST_W-1:0]))
		else $error("burst counter not loaded");
	burst_wrap_a: assert property (
		advStep |=> (burstCnt_ff == $past(burstCnt_ff) + BURST_STEP) && $stable(addrHi_ff))
		else $error("burst step wrong or high address moved");
	burst_hold_a: assert property (
		(~anyStrobe & stepSmp_n_ff) |=> $stable(burstCnt_ff))
		else $error("burst counter moved without advance");
	lane_qual_a: assert property (
		(allWrSmp_n_ff & laneEnSmp_n_ff) |=> arrayLaneWr_ff == RST_LANES)
		else $error("lane write without lane enable");
	lane_select_a: assert property (
		(accessCycle & allWrSmp_n_ff & ~laneEnSmp_n_ff) |=> arrayLaneWr_ff == ~$past(bwSmp_n_ff))
		else $error("lane selects not honoured");
	global_write_a: assert property (
		(accessCycle & ~allWrSmp_n_ff) |=> arrayLaneWr_ff == ALL_LANES)
		else $error("global write missed a lane");
	proc_ignore_a: assert property (
		// a running burst may still step with the select high, so hold advance off
		(sel1Smp_n_ff & ~procStbSmp_n_ff & ctrlStbSmp_n_ff & stepSmp_n_ff)
			|=> $stable(addrHi_ff) && $stable(burstCnt_ff))
		else $error("processor strobe taken while deselected");
	desel_decode_a: assert property (
		(anyStrobe & ~selActive) |=> deselected_ff && !burstActive_ff)
		else $error("deselect not taken");
	strobe_prio_a: assert property (
		(procStrobe & ~ctrlStbSmp_n_ff & selActive) |=> burstActive_ff)
		else $error("processor strobe lost priority");
	oe_direction_a: assert property (
		(oeSync_n_ff | sleepSync_ff) |=> dataOe_n_ff)
		else $error("pins driven with output enable high");
	first_mask_a: assert property (
		sReadIssue |=> dataOe_n_ff || !$past(maskFirst_ff) == 1'b1)
		else $error("output enable not masked after deselect");
	read_pipe_a: assert property (
		sReadIssue |=> dataOut_ff == $past(arrayRdData))
		else $error("read data not one stage behind");
	sleep_hold_a: assert property (
		sleepSync_ff |=> arrayLaneWr_ff == RST_LANES && sleeping_ff)
		else $error("array written during sleep");
	write_data_a: assert property (
		wrCycle |=> arrayWrData_ff == $past(dataSmp_ff))
		else $error("write data not taken with controls");
endmodule

// >>> verif/pssc_array_model.sv
// behavioural memory array behind the sram front end
`timescale 1ns/1ps
module pssc_array_model (
	input wire logic ref_clk,
	input wire logic [pssc_pkg::ADDR_W-1:0] arrayAddr,
	input wire logic [pssc_pkg::LANES-1:0] arrayLaneWr,
	input wire logic [pssc_pkg::DATA_W-1:0] arrayWrData,
	output logic [pssc_pkg::DATA_W-1:0] arrayRdData
);
	import pssc_pkg::*;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	// unwritten places answer an address pattern, never a stale word
	always_comb begin
		arrayRdData = mem.exists(arrayAddr) ? mem[arrayAddr] : {arrayAddr, ~arrayAddr};
	end
	always @(posedge ref_clk) begin
		// a partial write keeps the address pattern in the untouched lanes
		if (arrayLaneWr !== RST_LANES && !mem.exists(arrayAddr)) begin
			mem[arrayAddr] = {arrayAddr, ~arrayAddr};
		end
		for (int i = 0; i < LANES; i++) begin
			if (arrayLaneWr[i] === 1'b1) begin
				mem[arrayAddr][i*LANE_W +: LANE_W] = arrayWrData[i*LANE_W +: LANE_W];
			end
		end
	end
endmodule

// >>> verif/test_pssc_sram_front.sv
// self-checking bench for the sram control front end
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t mismatch got %h want %h", $time, a, b); end end
module test_pssc_sram_front;
	import pssc_pkg::*;
	typedef struct packed {logic [ADDR_W-1:0] a; logic [LANES-1:0] l; logic [DATA_W-1:0] d;} pssc_note_t;
	logic ref_clk = 0, sysRst = 1, procStb_n = 1, ctrlStb_n = 1, step_n = 1, allWr_n = 1;
	logic laneEn_n = 1, sel1_n = 1, sel2 = 0, sel3_n = 1, oe_n = 0, slp = 0, dataOe_n, sleeping;
	logic [LANES-1:0] laneSel_n = '1, arrayLaneWr, lanePick, laneWrAlt;
	logic [ADDR_W-1:0] addrIn = '0, arrayAddr, base;
	logic [DATA_W-1:0] dataIn = '0, dataOut, arrayRdData, arrayWrData, d;
	logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
	logic [ADDR_W-1:0] baddr [4];
	logic [7:0] badSel [3] = '{8'ha8, 8'hab, 8'h6e};
	pssc_note_t notes [$];
	pssc_note_t n;
	int fails = 0, checks_done = 0;
	always #12.5 ref_clk = ~ref_clk;
	pssc_sram_front dut (.ref_clk(ref_clk), .sys_rst(sysRst), .addrIn(addrIn),
		.processorAddrStrobe_n(procStb_n), .controllerAddrStrobe_n(ctrlStb_n),
		.burstAdvance_n(step_n), .globalWrite_n(allWr_n), .laneWriteEnable_n(laneEn_n),
		.byteLaneSelect_n(laneSel_n), .primarySelect_n(sel1_n), .secondSelect(sel2),
		.thirdSelect_n(sel3_n), .outputEnable_n(oe_n), .sleepRequest(slp), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe_n(dataOe_n), .arrayRdData(arrayRdData),
		.arrayAddr(arrayAddr), .arrayLaneWr(arrayLaneWr), .arrayWrData(arrayWrData),
		.sleeping(sleeping));
	// two-select build: third select held inactive must still select
	pssc_sram_front #(.HAS_THIRD_SELECT(1'b0)) dutAlt (.ref_clk(ref_clk), .sys_rst(sysRst),
		.addrIn(addrIn), .processorAddrStrobe_n(procStb_n), .controllerAddrStrobe_n(ctrlStb_n),
		.burstAdvance_n(step_n), .globalWrite_n(allWr_n), .laneWriteEnable_n(laneEn_n),
		.byteLaneSelect_n(laneSel_n), .primarySelect_n(sel1_n), .secondSelect(sel2),
		.thirdSelect_n(1'b1), .outputEnable_n(oe_n), .sleepRequest(slp), .dataIn(dataIn),
		.dataOut(), .dataOe_n(), .arrayRdData(arrayRdData), .arrayAddr(),
		.arrayLaneWr(laneWrAlt), .arrayWrData(), .sleeping());
	pssc_array_model array (.ref_clk(ref_clk), .arrayAddr(arrayAddr),
		.arrayLaneWr(arrayLaneWr), .arrayWrData(arrayWrData), .arrayRdData(arrayRdData));
	// ------------------------------------------------------------
	// driver helpers
	// ------------------------------------------------------------
	// control byte, msb first: proc strobe, ctrl strobe, step, all-write, lane enable, sel1..3
	task automatic bus(input logic [7:0] c, input logic [3:0] b, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] dd);
		@(posedge ref_clk);
		{procStb_n, ctrlStb_n, step_n, allWr_n, laneEn_n, sel1_n, sel2, sel3_n} <= c;
		laneSel_n <= b;
		addrIn <= a;
		dataIn <= dd;
	endtask
	task automatic note(input logic [ADDR_W-1:0] a, input logic [3:0] l, input logic [DATA_W-1:0] dd);
		notes.push_back({a, l, dd});
		// untouched lanes read back the array's address pattern
		if (!shadow.exists(a)) begin
			shadow[a] = {a, ~a};
		end
		for (int i = 0; i < LANES; i++) begin
			if (l[i]) begin
				shadow[a][i*LANE_W +: LANE_W] = dd[i*LANE_W +: LANE_W];
			end
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// monitor: every array write must match the oldest note
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		#1;
		if (sysRst === 1'b0 && arrayLaneWr !== RST_LANES) begin
			if (notes.size() == 0) begin
				fails++;
				$display("ERROR %0t array write with nothing expected", $time);
			end else begin
				n = notes.pop_front();
				`CHK(arrayAddr, n.a)
				`CHK(arrayLaneWr, n.l)
				`CHK(laneWrAlt, n.l)
				`CHK(arrayWrData, n.d)
			end
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(75033));
		repeat (2) @(posedge ref_clk);
		sysRst <= 1'b0;
		#1;
		`CHK(dataOe_n, 1'b1)
		base = ADDR_W'($urandom);
		base[1:0] = 2'h3;
		// global-write burst from offset 3 must wrap to 0,1,2
		for (int i = 0; i < 4; i++) begin
			d = DATA_W'({$urandom, $urandom});
			bus(i == 0 ? 8'haa : 8'hca, 4'h0, i == 0 ? base : ADDR_W'($urandom), d);
			note({base[ADDR_W-1:2], 2'(3 + i)}, ALL_LANES, d);
		end
		for (int k = 0; k < 4; k++) begin
			baddr[k] = ADDR_W'($urandom);
			lanePick = LANES'($urandom);
			lanePick[k] = 1'b0;
			d = DATA_W'({$urandom, $urandom});
			bus(8'hb2, lanePick, baddr[k], d);
			note(baddr[k], ~lanePick, d);
		end
		bus(8'hba, 4'h0, baddr[0], d);
		d = DATA_W'({$urandom, $urandom});
		bus(8'h2a, 4'h0, baddr[1], d);
		note(baddr[1], ALL_LANES, d);
		foreach (badSel[j]) bus(badSel[j], 4'h0, ADDR_W'($urandom), d);
		bus(8'hfa, 4'hf, base, d);
		bus(8'h7a, 4'hf, base, d);
		bus(8'h7a, 4'hf, baddr[2], d);
		bus(8'hfa, 4'hf, base, d);
		@(posedge ref_clk);
		#1;
		`CHK(dataOut, shadow[base])
		`CHK(dataOe_n, 1'b1)
		@(posedge ref_clk);
		#1;
		`CHK(dataOut, shadow[baddr[2]])
		`CHK(dataOe_n, 1'b0)
		@(posedge ref_clk);
		oe_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(dataOe_n, 1'b1)
		@(posedge ref_clk);
		oe_n <= 1'b0;
		slp <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(sleeping, 1'b1)
		bus(8'haa, 4'h0, base, d);
		bus(8'hfa, 4'hf, base, d);
		repeat (4) @(posedge ref_clk);
		slp <= 1'b0;
		repeat (6) @(posedge ref_clk);
		`CHK(notes.size(), 0)
		tally_and_finish();
	end
endmodule
